/* logic/cri_config_loader.sv */
// Configuration loader with AXI4-Lite status registers
`timescale 1ns/10ps
`include "cri_defs.svh"
module cri_config_loader (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Memory byte reader
    output logic mem_rd_req,
    output logic [8:0] mem_rd_addr,
    input wire logic mem_rd_ack,
    input wire logic [7:0] mem_rd_data,
    output logic [7:0] cfg_wr_data,
    output logic [8:0] cfg_wr_addr,
    output logic cfg_wr_en,
    // Protection interrupt summary in, loader event interrupt out
    input wire logic protect_irq_pending,
    output logic irq
);
    // Loader state
    cri_pkg::cri_state_e st_q;
    cri_pkg::cri_state_e st_d;
    logic [8:0] addr_q;
    logic [8:0] addr_d;
    logic [7:0] settle_q;
    logic [7:0] settle_d;
    logic reload_q;
    logic reload_d;
    logic cfg_done_q;
    logic cfg_done_d;
    logic init_done_q;
    logic init_done_d;
    logic sum_ok_q;
    logic sum_ok_d;
    logic [7:0] cfg_data_q;
    logic [7:0] cfg_data_d;
    logic cfg_en_q;
    logic cfg_en_d;
    // Interrupt state
    logic [2:0] ists_q;
    logic [2:0] ists_d;
    logic [2:0] imsk_q;
    logic [2:0] imsk_d;
    // Bus state
    logic aw_q;
    logic aw_d;
    logic w_q;
    logic w_d;
    logic [7:0] awa_q;
    logic [7:0] awa_d;
    logic [31:0] wd_q;
    logic [31:0] wd_d;
    logic [3:0] ws_q;
    logic [3:0] ws_d;
    logic bv_q;
    logic bv_d;
    logic [1:0] br_q;
    logic [1:0] br_d;
    logic rv_q;
    logic rv_d;
    logic [31:0] rd_q;
    logic [31:0] rd_d;
    logic [1:0] rr_q;
    logic [1:0] rr_d;
    // Helpers
    logic wr_fire;
    logic start_load;
    logic sum_clear;
    logic sum_ok;
    logic [7:0] status;
    logic [2:0] ev;

    // Status byte as software sees it
    always_comb begin
        status = 8'h00;
        status[`CRI_STS_SUM_BIT] = sum_ok_q;
        status[`CRI_STS_CFG_BIT] = cfg_done_q;
        status[`CRI_STS_INIT_BIT] = init_done_q;
        status[`CRI_STS_PROT_BIT] = protect_irq_pending;
    end

    // Write fires when both address and data are held
    assign wr_fire = aw_q && w_q && !bv_q;
    // Only a one written to the reload bit starts a load
    assign start_load = wr_fire && awa_q == `CRI_OFS_CTRL && ws_q[0]
        && wd_q[`CRI_CTRL_RELOAD_BIT] && !reload_q;
    assign sum_clear = start_load;

    // Checksum accumulator
    cri_sum_acc u_sum (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .clear(sum_clear),
        .byte_vld(st_q == cri_pkg::CRI_WAIT && mem_rd_ack),
        .byte_addr(addr_q),
        .byte_data(mem_rd_data),
        .sum_ok(sum_ok)
    );

    // Loader sequence next state
    always_comb begin
        st_d = st_q;
        addr_d = addr_q;
        settle_d = settle_q;
        reload_d = reload_q;
        cfg_done_d = cfg_done_q;
        init_done_d = init_done_q;
        sum_ok_d = sum_ok_q;
        cfg_data_d = cfg_data_q;
        cfg_en_d = 1'b0;
        unique case (st_q)
            cri_pkg::CRI_IDLE: begin
                if (start_load) begin
                    // Config and init done status bits drop while reloading
                    reload_d = 1'b1;
                    cfg_done_d = 1'b0;
                    init_done_d = 1'b0;
                    addr_d = 9'h1FF; // Wraps to zero in the request step
                    st_d = cri_pkg::CRI_REQ;
                end
            end
            cri_pkg::CRI_REQ: begin
                // Step here so the forwarded byte keeps its own address
                addr_d = addr_q + 9'h001;
                st_d = cri_pkg::CRI_WAIT;
            end
            cri_pkg::CRI_WAIT: begin
                if (mem_rd_ack) begin
                    // Forward each byte into configuration space
                    cfg_data_d = mem_rd_data;
                    cfg_en_d = 1'b1;
                    if (addr_q == `CRI_MEM_BYTES - 9'h001) begin
                        cfg_done_d = 1'b1;
                        settle_d = 8'(`CRI_INIT_SETTLE_CYC);
                        st_d = cri_pkg::CRI_SETTLE;
                    end else begin
                        st_d = cri_pkg::CRI_REQ;
                    end
                end
            end
            cri_pkg::CRI_SETTLE: begin
                // Checksum result latched after last byte summed
                sum_ok_d = sum_ok;
                if (settle_q == 8'h01) begin
                    st_d = cri_pkg::CRI_DONE;
                end else begin
                    settle_d = settle_q - 8'h01;
                end
            end
            cri_pkg::CRI_DONE: begin
                init_done_d = 1'b1;
                reload_d = 1'b0;
                st_d = cri_pkg::CRI_IDLE;
            end
            default: begin
                st_d = cri_pkg::CRI_IDLE;
            end
        endcase
    end

    // Loader registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= cri_pkg::CRI_IDLE;
            addr_q <= 9'h000;
            settle_q <= 8'h00;
            reload_q <= 1'b0;
            cfg_done_q <= 1'b0;
            init_done_q <= 1'b0;
            sum_ok_q <= 1'b1;
            cfg_data_q <= 8'h00;
            cfg_en_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            addr_q <= addr_d;
            settle_q <= settle_d;
            reload_q <= reload_d;
            cfg_done_q <= cfg_done_d;
            init_done_q <= init_done_d;
            sum_ok_q <= sum_ok_d;
            cfg_data_q <= cfg_data_d;
            cfg_en_q <= cfg_en_d;
        end
    end

    // Memory and configuration ports
    assign mem_rd_req = (st_q == cri_pkg::CRI_WAIT);
    assign mem_rd_addr = addr_q;
    assign cfg_wr_data = cfg_data_q;
    assign cfg_wr_addr = addr_q;
    assign cfg_wr_en = cfg_en_q;

    // Events: config done, init done, checksum fail
    assign ev[0] = cfg_done_d && !cfg_done_q;
    assign ev[1] = init_done_d && !init_done_q;
    assign ev[2] = st_q == cri_pkg::CRI_DONE && !sum_ok_q;

    // Sticky status, write one clears, set beats clear
    always_comb begin
        ists_d = ists_q;
        imsk_d = imsk_q;
        if (wr_fire && ws_q[0]) begin
            if (awa_q == `CRI_OFS_IRQ_STS) begin
                ists_d = ists_q & ~wd_q[2:0];
            end
            if (awa_q == `CRI_OFS_IRQ_MSK) begin
                imsk_d = wd_q[2:0];
            end
        end
        ists_d = ists_d | ev;
    end

    // Interrupt registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ists_q <= 3'h0;
            imsk_q <= 3'h0;
        end else if (clk_en) begin
            ists_q <= ists_d;
            imsk_q <= imsk_d;
        end
    end

    assign irq = |(ists_q & imsk_q);

    // Bus channel next values
    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        // Capture write address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            // Status is read-only; write silently accepted
            unique case (awa_q)
                `CRI_OFS_CTRL, `CRI_OFS_STATUS, `CRI_OFS_IRQ_STS, `CRI_OFS_IRQ_MSK: br_d = 2'h0;
                default: br_d = 2'h2;
            endcase
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        // Read answer one cycle after address
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rr_d = 2'h0;
            unique case (s_axi_araddr)
                `CRI_OFS_CTRL: rd_d = {30'h0, reload_q, 1'b0};
                `CRI_OFS_STATUS: rd_d = {24'h0, status};
                `CRI_OFS_IRQ_STS: rd_d = {29'h0, ists_q};
                `CRI_OFS_IRQ_MSK: rd_d = {29'h0, imsk_q};
                default: begin
                    rd_d = 32'h0;
                    rr_d = 2'h2;
                end
            endcase
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    // Bus registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            bv_q <= 1'b0;
            br_q <= 2'h0;
            rv_q <= 1'b0;
            rd_q <= 32'h0;
            rr_q <= 2'h0;
        end else if (clk_en) begin
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
        end
    end

    // Ready terms; stall while frozen
    assign s_axi_awready = clk_en && !aw_q && !bv_q;
    assign s_axi_wready = clk_en && !w_q && !bv_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = clk_en && !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
endmodule : cri_config_loader

/* logic/cri_defs.svh */
// Constants of the configuration reload and initialisation status block
`ifndef CRI_DEFS_SVH
`define CRI_DEFS_SVH
`define CRI_OFS_CTRL 8'h4C
`define CRI_OFS_STATUS 8'h50
`define CRI_OFS_IRQ_STS 8'h58
`define CRI_OFS_IRQ_MSK 8'h5C
`define CRI_CTRL_RELOAD_BIT 1
`define CRI_STS_SUM_BIT 1
`define CRI_STS_CFG_BIT 2
`define CRI_STS_INIT_BIT 4
`define CRI_STS_PROT_BIT 5
`define CRI_STS_RESET 8'h02
`define CRI_MEM_BYTES 9'h100
`define CRI_SUM_START 9'h080
`define CRI_INIT_SETTLE_NS 100
`define CRI_INIT_SETTLE_CYC ((`CRI_INIT_SETTLE_NS + 9) / 10)
`endif

/* logic/cri_pkg.sv */
// Types of the configuration reload and initialisation status block
package cri_pkg;
    typedef enum logic [2:0] {
        CRI_IDLE = 3'b000,
        CRI_REQ = 3'b001,
        CRI_WAIT = 3'b010,
        CRI_SETTLE = 3'b011,
        CRI_DONE = 3'b100
    } cri_state_e;
    typedef logic [7:0] cri_byte_t;
endpackage : cri_pkg

/* logic/cri_sum_acc.sv */
// Checksum accumulator over the tail of the configuration memory
`timescale 1ns/10ps
`include "cri_defs.svh"
module cri_sum_acc (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic byte_vld,
    input wire logic [8:0] byte_addr,
    input wire logic [7:0] byte_data,
    output logic sum_ok
);
    // Running byte sum
    logic [7:0] sum_q;
    logic [7:0] sum_d;

    // Only the last 128 bytes count; a valid block sums to zero
    always_comb begin
        sum_d = sum_q;
        if (clear) begin
            sum_d = 8'h00;
        end else if (byte_vld && byte_addr >= `CRI_SUM_START) begin
            sum_d = sum_q + byte_data;
        end
    end

    // Register stage
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sum_q <= 8'h00;
        end else if (clk_en) begin
            sum_q <= sum_d;
        end
    end

    // Two's complement sum passes when total is zero
    assign sum_ok = (sum_q == 8'h00);
endmodule : cri_sum_acc

/* verif/cri_config_checker.sv */
// Port assertions of the configuration loader
`timescale 1ns/10ps
module cri_config_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mem_rd_req,
    input wire logic mem_rd_ack,
    input wire logic cfg_wr_en,
    input wire logic protect_irq_pending,
    input wire logic irq,
    input wire logic [8:0] mem_rd_addr,
    input wire logic [8:0] cfg_wr_addr,
    input wire logic [7:0] mem_rd_data,
    input wire logic [7:0] cfg_wr_data
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Reload request must start the memory walk soon
    property p_reload;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 8'h4C
            && s_axi_wdata[1] && !mem_rd_req |-> ##[1:6] mem_rd_req;
    endproperty
    a_reload: assert property (p_reload) else $error("reload did not start");
    // Zero reload writes and status writes leave the memory alone
    property p_no_load;
        s_axi_awvalid && s_axi_awready && !mem_rd_req
            && ((s_axi_awaddr == 8'h4C && !s_axi_wdata[1]) || s_axi_awaddr == 8'h50) |=> !mem_rd_req [*4];
    endproperty
    a_no_load: assert property (p_no_load) else $error("load started without request");
    // Address held while a byte is outstanding
    property p_addr_hold;
        mem_rd_req && !mem_rd_ack |=> $stable(mem_rd_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("memory address moved");
    // Each answered byte before the last steps the address by one, in the request step after it
    property p_addr_step;
        mem_rd_req && mem_rd_ack && mem_rd_addr != 9'h0FF |-> ##2 mem_rd_addr == $past(mem_rd_addr, 2) + 9'h001;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("memory address did not step");
    // Fetched byte is handed on the next cycle
    property p_copy;
        mem_rd_req && mem_rd_ack |=> cfg_wr_en && cfg_wr_data == $past(mem_rd_data);
    endproperty
    a_copy: assert property (p_copy) else $error("fetched byte not passed on");
    // Forwarded byte carries the address it was fetched from
    property p_cfg_addr;
        cfg_wr_en |-> cfg_wr_addr == $past(mem_rd_addr);
    endproperty
    a_cfg_addr: assert property (p_cfg_addr) else $error("forwarded byte has wrong address");
    // Walk ends at the last byte, settle follows
    property p_settle;
        mem_rd_req && mem_rd_ack && mem_rd_addr == 9'h0FF |=> !mem_rd_req [*8];
    endproperty
    a_settle: assert property (p_settle) else $error("read past the last byte");
    // Read answer holds until taken
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    // Write answer follows capture of both halves
    property p_bresp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write answer missing");
    // Unmapped read gives error and zero
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
endmodule : cri_config_checker
bind cri_config_loader cri_config_checker u_chk (.*);

/* verif/cri_mem_model.sv */
// Configuration memory model answering byte reads
`timescale 1ns/10ps
module cri_mem_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic mem_rd_req,
    input wire logic [8:0] mem_rd_addr,
    output logic mem_rd_ack,
    output logic [7:0] mem_rd_data,
    input wire logic bad_sum,
    input wire logic slow
);
    logic [1:0] wait_q; // Cycles waited for this byte
    logic [7:0] byte_v; // Stored byte at the address
    // Bytes hold their address; last one closes the tail sum to zero
    always_comb begin
        byte_v = (mem_rd_addr[7:0] == 8'hFF) ? (bad_sum ? 8'h40 : 8'h3F) : mem_rd_addr[7:0];
        // Inverted outside the answer so no stale value passes
        mem_rd_data = mem_rd_ack ? byte_v : ~byte_v;
    end
    // One-cycle answer, slow mode waits longer
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_rd_ack <= 1'b0;
            wait_q <= 2'h0;
        end else begin
            mem_rd_ack <= mem_rd_req && !mem_rd_ack && wait_q == (slow ? 2'h2 : 2'h0);
            wait_q <= (mem_rd_req && !mem_rd_ack && wait_q != 2'h3) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule : cri_mem_model

/* verif/cri_config_loader_bench.sv */
// Self-checking bench of the configuration loader
`timescale 1ns/10ps
module cri_config_loader_bench;
    logic sys_clk, rst_b, clk_en, protect_irq_pending, irq, bad_sum, slow;
    logic [7:0] s_axi_awaddr, s_axi_araddr, mem_rd_data, cfg_wr_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs_v;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mem_rd_req, mem_rd_ack, cfg_wr_en;
    logic [8:0] mem_rd_addr, cfg_wr_addr;
    int n_errors, cmp_count;
    cri_config_loader uut (.*);
    cri_mem_model mem (.*);
    // Free running clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Write with both halves offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            t++;
        end while (!s_axi_bvalid && t < 100);
        // A missing answer ends the run as a failure
        if (!s_axi_bvalid) begin
            n_errors++;
            give_verdict;
        end else begin
            rs_v = s_axi_bresp;
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int t;
        t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            t++;
        end while (!s_axi_rvalid && t < 100);
        // A missing answer ends the run as a failure
        if (!s_axi_rvalid) begin
            n_errors++;
            give_verdict;
        end else begin
            rd_v = s_axi_rdata;
            rs_v = s_axi_rresp;
        end
    endtask : rd
    task automatic t_reset;
        rd(8'h50);
        chk("status", 32'h02, rd_v);
        rd(8'h4C);
        chk("control", 32'h0, rd_v);
        $display("test reset done");
    endtask : t_reset
    task automatic t_pend;
        protect_irq_pending <= 1'b1;
        rd(8'h50);
        chk("pend status", 32'h22, rd_v);
        wr(8'h50, 32'hFF);
        chk("status write resp", 32'h0, rs_v);
        rd(8'h50);
        chk("status after write", 32'h22, rd_v);
        protect_irq_pending <= 1'b0;
        rd(8'h50);
        chk("pend gone", 32'h02, rd_v);
        $display("test pend done");
    endtask : t_pend
    task automatic t_load(input logic b, input logic s, input logic [31:0] es, input logic [31:0] ei);
        int t;
        logic seen;
        bad_sum <= b;
        slow <= s;
        seen = 1'b0;
        t = 0;
        wr(8'h4C, 32'h2);
        rd(8'h4C);
        chk("reload busy", 32'h2, rd_v);
        rd(8'h50);
        chk("not done yet", 32'h0, rd_v & 32'h14);
        // Poll until init done, noting config done alone
        do begin
            rd(8'h50);
            if (rd_v[2] && !rd_v[4]) seen = 1'b1;
            t++;
        end while (!rd_v[4] && t < 2000);
        chk("cfg before init", 32'h1, {31'h0, seen});
        chk("final status", es, rd_v);
        rd(8'h4C);
        chk("reload cleared", 32'h0, rd_v);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h5C, 32'h7);
        chk("irq up", 32'h1, {31'h0, irq});
        rd(8'h58);
        chk("events", ei, rd_v);
        wr(8'h58, 32'h7);
        @(posedge sys_clk);
        chk("irq down", 32'h0, {31'h0, irq});
        wr(8'h5C, 32'h0);
        $display("test load done");
    endtask : t_load
    task automatic t_misc;
        int t;
        t = 0;
        wr(8'h4C, 32'h0);
        // Zero write must not wake the memory
        repeat (20) begin
            @(posedge sys_clk);
            if (mem_rd_req !== 1'b0) t++;
        end
        chk("zero write idle", 32'h0, t);
        rd(8'h10);
        chk("unmapped resp", 32'h2, {30'h0, rs_v});
        chk("unmapped data", 32'h0, rd_v);
        // Frozen clock enable drops the read and write address readies
        clk_en <= 1'b0;
        @(posedge sys_clk);
        chk("frozen arready", 32'h0, {31'h0, s_axi_arready});
        chk("frozen awready", 32'h0, {31'h0, s_axi_awready});
        clk_en <= 1'b1;
        @(posedge sys_clk);
        chk("thawed arready", 32'h1, {31'h0, s_axi_arready});
        $display("test misc done");
    endtask : t_misc
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    // Main sequence; ready lines held high throughout
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        protect_irq_pending = 1'b0;
        bad_sum = 1'b0;
        slow = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        n_errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        t_reset;
        t_pend;
        t_load(1'b0, 1'b0, 32'h16, 32'h3);
        t_load(1'b1, 1'b1, 32'h14, 32'h7);
        t_misc;
        give_verdict;
    end
    // Watchdog well beyond the expected run
    initial begin
        #300000;
        n_errors++;
        give_verdict;
    end
endmodule : cri_config_loader_bench
